// *** ddr2_auto_precharge_timing.sv ***
// Contract
// [RULE_01] read/write with A10 low: plain burst, bank stays open
// [RULE_02] read/write with A10 high: arm auto precharge for that bank
// [RULE_03] read AP closes bank CL cycles before last read data
// [RULE_04] write AP waits until last write beat is stored
// [RULE_05] auto precharge is held internally until tRAS elapsed
// [RULE_06] read AP starts AL + BL/2 edges after command if timings met
// [RULE_07] tRAS not met at that edge: wait until it is
// [RULE_08] tRTP not met at that edge: wait until it is
// [RULE_09] when pushed by tRTP, tRP counts from exact tRTP end
// [RULE_10] controller: BL4 read AP to activate AL + RU(tRTP+tRP)
// [RULE_11] controller: BL8 read AP to activate AL + 2 + RU(tRTP+tRP)
// [RULE_12] precharge never starts before two clocks after last prefetch
// [RULE_13] controller: reactivate after tRP from precharge and tRC
// [RULE_14] write AP starts after burst end plus programmed WR
// [RULE_15] controller: write AP reactivate after WR + tRP and tRC
// [RULE_16] controller: read to precharge AL + BL/2 + max(RTP,2) - 2
// [RULE_17] controller: write to precharge WL + BL/2 + tWR
// [RULE_18] controller: write AP to precharge WL + BL/2 + WR
// [RULE_19] controller: one clock between two precharge commands
// [RULE_20] RTP cycles are tRTP over clock period, rounded up
// [RULE_21] precharge period timed from latest precharge to the bank
// [RULE_22] write latency is AL + CL - 1
// [RULE_23] read latency is AL + CL
// [RULE_24] separate timers per bank so all four can auto precharge
`timescale 1ns/1ps
module ddr2_auto_precharge_timing (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CK,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BA,
  input wire logic A10,
  input wire logic [2:0] AL,
  input wire logic [2:0] CL,
  input wire logic [2:0] WR,
  input wire logic BL8,
  output logic [ap_timing_pkg::NB-1:0] BANK_OPEN,
  output logic [ap_timing_pkg::NB-1:0] AP_PENDING,
  output logic [ap_timing_pkg::NB-1:0] PRECHARGING,
  output logic [ap_timing_pkg::NB-1:0] AP_START,
  output logic [3:0] RD_LATENCY,
  output logic [3:0] WR_LATENCY
);
  import ap_timing_pkg::*;

  logic [PIN_W-1:0] pins_s;
  logic ck_rise;
  logic c_act;
  logic c_pre;
  logic c_rd;
  logic c_wr;
  logic [1:0] c_ba;
  logic c_a10;

  bank_st_t st_reg [NB];
  logic [CW-1:0] edge_reg [NB];
  logic [CW-1:0] pf_reg [NB];
  logic pf_run_reg [NB];
  logic [TW-1:0] ras_reg [NB];
  logic [TW-1:0] rtp_reg [NB];
  logic [TW-1:0] rp_reg [NB];
  logic [NB-1:0] hit;
  logic [NB-1:0] ap_go;

  function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
    return (v == '0) ? v : v - CW'(1);
  endfunction : dec

  function automatic logic [TW-1:0] dec_t(input logic [TW-1:0] v);
    return (v == '0) ? v : v - TW'(1);
  endfunction : dec_t

  function automatic logic [CW-1:0] half_bl(input logic bl8);
    return bl8 ? CW'(BL8_HALF) : CW'(BL4_HALF);
  endfunction : half_bl

  pin_sync #(
    .W(PIN_W)
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .d({CK, CS_N, RAS_N, CAS_N, WE_N, BA, A10}),
    .q(pins_s)
  );

  cmd_decode u_dec (
    .clk(CLK),
    .rst(RST),
    .pins(pins_s),
    .rise_reg(ck_rise),
    .act_reg(c_act),
    .pre_reg(c_pre),
    .rd_reg(c_rd),
    .wr_reg(c_wr),
    .ba_reg(c_ba),
    .a10_reg(c_a10)
  );

  always_comb
  begin
    for (int b = 0; b < NB; b++)
    begin
      hit[b] = (c_ba == 2'(b));
      // [RULE_05] [RULE_07] [RULE_08] start gate
      ap_go[b] = (st_reg[b] == ST_ARMED) && (edge_reg[b] == '0) &&
                 (ras_reg[b] == '0) && (rtp_reg[b] == '0) &&
                 !pf_run_reg[b];
    end
  end

  // [RULE_24] one state machine per bank
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST)
        st_reg[b] <= ST_IDLE;
      else
        case (st_reg[b])
          ST_IDLE:
            if (c_act && hit[b])
              st_reg[b] <= ST_OPEN;
          ST_OPEN:
            // [RULE_01] [RULE_02] A10 picks open or armed
            if ((c_rd || c_wr) && hit[b] && c_a10)
              st_reg[b] <= ST_ARMED;
            else if (c_pre && (hit[b] || c_a10))
              st_reg[b] <= ST_PRECH;
          ST_ARMED:
            if (ap_go[b])
              st_reg[b] <= ST_PRECH;
          ST_PRECH:
            if (rp_reg[b] == '0 && !(c_pre && (hit[b] || c_a10)))
              st_reg[b] <= ST_IDLE;
          default:
            st_reg[b] <= ST_IDLE;
        endcase
    end
  end

  // memory clock edges left until the auto precharge start point
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST)
        edge_reg[b] <= '0;
      else if (c_rd && hit[b] && c_a10)
        // [RULE_03] [RULE_06] [RULE_12] start AL + BL/2
        edge_reg[b] <= CW'(AL) + half_bl(BL8);
      else if (c_wr && hit[b] && c_a10)
        // [RULE_04] [RULE_14] WL + BL/2 burst end, then WR
        edge_reg[b] <= CW'(AL) + CW'(CL) - CW'(WL_OFS) + half_bl(BL8) +
                       CW'(WR);
      else if (ck_rise)
        edge_reg[b] <= dec(edge_reg[b]);
    end
  end

  // last prefetch edge, then tRTP in system cycles
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST)
      begin
        pf_reg[b] <= '0;
        pf_run_reg[b] <= 1'b0;
        rtp_reg[b] <= '0;
      end
      else if (c_rd && hit[b] && c_a10)
      begin
        pf_reg[b] <= CW'(AL) + (BL8 ? CW'(BL8_PF_OFS) : CW'(0));
        pf_run_reg[b] <= 1'b1;
        rtp_reg[b] <= '0;
      end
      else if (pf_run_reg[b] && pf_reg[b] == '0)
      begin
        // [RULE_20] RTP rounded up from the analog time
        pf_run_reg[b] <= 1'b0;
        rtp_reg[b] <= TW'(RTP_CYC);
      end
      else
      begin
        if (ck_rise)
          pf_reg[b] <= dec(pf_reg[b]);
        // [RULE_09] counted on system clock, not memory edges
        rtp_reg[b] <= dec_t(rtp_reg[b]);
      end
    end
  end

  // row active time from each activate
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST)
        ras_reg[b] <= '0;
      else if (c_act && hit[b])
        ras_reg[b] <= TW'(RAS_CYC);
      else
        ras_reg[b] <= dec_t(ras_reg[b]);
    end
  end

  // precharge period; a later precharge restarts it
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST)
        rp_reg[b] <= '0;
      else if (ap_go[b])
        rp_reg[b] <= TW'(RP_CYC);
      // [RULE_21] latest single or all-bank precharge
      else if (c_pre && (hit[b] || c_a10) &&
               (st_reg[b] == ST_OPEN || st_reg[b] == ST_PRECH))
        rp_reg[b] <= TW'(RP_CYC);
      else
        rp_reg[b] <= dec_t(rp_reg[b]);
    end
  end

  // status outputs lag the bank state by one cycle; AP_START lags ap_go by one cycle
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST)
      begin
        BANK_OPEN[b] <= 1'b0;
        AP_PENDING[b] <= 1'b0;
        PRECHARGING[b] <= 1'b0;
        AP_START[b] <= 1'b0;
      end
      else
      begin
        BANK_OPEN[b] <= (st_reg[b] == ST_OPEN) || (st_reg[b] == ST_ARMED);
        AP_PENDING[b] <= (st_reg[b] == ST_ARMED);
        PRECHARGING[b] <= (st_reg[b] == ST_PRECH);
        AP_START[b] <= ap_go[b];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      RD_LATENCY <= 4'h0;
      WR_LATENCY <= 4'h0;
    end
    else
    begin
      // [RULE_23] read latency
      RD_LATENCY <= 4'(AL) + 4'(CL);
      // [RULE_22] write latency
      WR_LATENCY <= 4'(AL) + 4'(CL) - 4'(WL_OFS);
    end
  end

  // helper: memory edges seen since the last prefetch of a read AP
  logic [CW-1:0] since_pf_reg [NB];
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST || (c_rd && hit[b]))
        since_pf_reg[b] <= '0;
      else if (pf_run_reg[b] && pf_reg[b] == '0)
        since_pf_reg[b] <= '0;
      else if (ck_rise && since_pf_reg[b] != '1)
        since_pf_reg[b] <= since_pf_reg[b] + CW'(1);
    end
  end

  // helper: read AP pending on this bank
  logic [NB-1:0] rd_ap_reg;
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (RST || ap_go[b] || (c_wr && hit[b]))
        rd_ap_reg[b] <= 1'b0;
      else if (c_rd && hit[b] && c_a10)
        rd_ap_reg[b] <= 1'b1;
    end
  end

  for (genvar g = 0; g < NB; g++)
  begin : g_chk
    property p_plain_open;
      @(posedge CLK) disable iff (RST)
      (st_reg[g] == ST_OPEN && (c_rd || c_wr) && hit[g] && !c_a10 &&
       !c_pre) |=> (st_reg[g] == ST_OPEN);
    endproperty
    a_plain_open: assert property (p_plain_open) // [RULE_01]
      else $error("bank closed after plain access");

    property p_arm;
      @(posedge CLK) disable iff (RST)
      (st_reg[g] == ST_OPEN && c_rd && hit[g] && c_a10)
        |=> (st_reg[g] == ST_ARMED) ##1 AP_PENDING[g];
    endproperty
    a_arm: assert property (p_arm) // [RULE_02]
      else $error("auto precharge not armed");

    property p_ras;
      @(posedge CLK) disable iff (RST)
      (st_reg[g] == ST_ARMED && ras_reg[g] != '0)
        |=> (st_reg[g] != ST_PRECH);
    endproperty
    a_ras: assert property (p_ras) // [RULE_05]
      else $error("precharge before row active time");

    property p_rtp;
      @(posedge CLK) disable iff (RST)
      $fell(pf_run_reg[g]) && st_reg[g] == ST_ARMED
        |-> !ap_go[g] [*1] ##1 (rtp_reg[g] == TW'(RTP_CYC) - TW'(1));
    endproperty
    a_rtp: assert property (p_rtp) // [RULE_08]
      else $error("read to precharge time not honoured");

    property p_edge;
      @(posedge CLK) disable iff (RST)
      (st_reg[g] == ST_ARMED && edge_reg[g] != '0) |-> !ap_go[g];
    endproperty
    a_edge: assert property (p_edge) // [RULE_06]
      else $error("auto precharge before start edge");

    property p_pf_gap;
      @(posedge CLK) disable iff (RST)
      (ap_go[g] && rd_ap_reg[g]) |-> (since_pf_reg[g] >= CW'(PF_GAP));
    endproperty
    a_pf_gap: assert property (p_pf_gap) // [RULE_12]
      else $error("precharge too soon after last prefetch");

    property p_rp;
      @(posedge CLK) disable iff (RST)
      ap_go[g] |=> (st_reg[g] == ST_PRECH && rp_reg[g] == TW'(RP_CYC))
        ##1 (st_reg[g] == ST_PRECH);
    endproperty
    a_rp: assert property (p_rp) // [RULE_21]
      else $error("precharge period not timed from start");

    property p_start_out;
      @(posedge CLK) disable iff (RST)
      ap_go[g] |=> AP_START[g] ##1 PRECHARGING[g];
    endproperty
    a_start_out: assert property (p_start_out) // [RULE_24]
      else $error("start pulse or precharge flag missing");
  end

  property p_wl;
    @(posedge CLK) disable iff (RST)
    $stable(AL) && $stable(CL) && CL != 3'h0
      |=> (WR_LATENCY + 4'h1 == RD_LATENCY);
  endproperty
  a_wl: assert property (p_wl) // [RULE_22]
    else $error("write latency not read latency minus one");
endmodule : ddr2_auto_precharge_timing

// *** ap_timing_pkg.sv ***
package ap_timing_pkg;
  localparam int NB = 4;
  localparam int CW = 6;
  localparam int TW = 8;
  localparam int PIN_W = 8;
  localparam int CLK_PS = 40000;
  localparam int T_RAS_PS = 45000;
  localparam int T_RTP_PS = 7500;
  localparam int T_RP_PS = 15000;
  localparam int BL4_HALF = 2;
  localparam int BL8_HALF = 4;
  localparam int BL8_PF_OFS = 2;
  localparam int PF_GAP = 2;
  localparam int WL_OFS = 1;

  // least times: round up, never below one cycle
  function automatic int ru_cyc(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction : ru_cyc

  localparam int RAS_CYC = ru_cyc(T_RAS_PS);
  localparam int RTP_CYC = ru_cyc(T_RTP_PS);
  localparam int RP_CYC = ru_cyc(T_RP_PS);

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;

  // synchronised pin vector layout
  localparam int PIN_CK = 7;
  localparam int PIN_CMD_HI = 6;
  localparam int PIN_CMD_LO = 3;
  localparam int PIN_BA_HI = 2;
  localparam int PIN_BA_LO = 1;
  localparam int PIN_A10 = 0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_OPEN = 4'h2,
    ST_ARMED = 4'h4,
    ST_PRECH = 4'h8
  } bank_st_t;
endpackage : ap_timing_pkg

// *** pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : pin_sync

// *** cmd_decode.sv ***
`timescale 1ns/1ps
module cmd_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ap_timing_pkg::PIN_W-1:0] pins,
  output logic rise_reg,
  output logic act_reg,
  output logic pre_reg,
  output logic rd_reg,
  output logic wr_reg,
  output logic [1:0] ba_reg,
  output logic a10_reg
);
  import ap_timing_pkg::*;

  logic ck_d_reg;
  logic rise;
  logic [3:0] code;

  assign rise = pins[PIN_CK] & ~ck_d_reg;
  assign code = pins[PIN_CMD_HI:PIN_CMD_LO];

  always_ff @(posedge clk)
  begin
    if (rst)
      ck_d_reg <= 1'b0;
    else
      ck_d_reg <= pins[PIN_CK];
  end

  // command is latched on the memory clock rising edge only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rise_reg <= 1'b0;
      act_reg <= 1'b0;
      pre_reg <= 1'b0;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      ba_reg <= 2'h0;
      a10_reg <= 1'b0;
    end
    else
    begin
      rise_reg <= rise;
      act_reg <= rise && (code == CMD_ACT);
      pre_reg <= rise && (code == CMD_PRE);
      rd_reg <= rise && (code == CMD_READ);
      wr_reg <= rise && (code == CMD_WRITE);
      if (rise)
      begin
        ba_reg <= pins[PIN_BA_HI:PIN_BA_LO];
        a10_reg <= pins[PIN_A10];
      end
    end
  end
endmodule : cmd_decode

// *** ctrl_model.sv ***
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk,
  input wire logic ck,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic a10
);
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 2'h0;
    a10 = 1'b0;
  end

  // drive after a fall, hold across the rise until the next fall
  // spaced precharge commands
  task automatic issue(input logic [3:0] cmd, input logic [1:0] b,
                       input logic f);
    @(negedge ck);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= cmd;
    ba <= b;
    a10 <= f;
    @(negedge ck);
    @(posedge clk);
    // deselected: address lines must not keep the old value
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    ba <= ~b;
    a10 <= ~f;
  endtask : issue

  task automatic gap(input int n);
    repeat (n) @(posedge ck);
  endtask : gap
endmodule : ctrl_model

// *** ddr2_auto_precharge_timing_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module ddr2_auto_precharge_timing_tb_top;
  import ap_timing_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ck = 1'b0;
  logic cs_n, ras_n, cas_n, we_n, a10;
  logic [1:0] ba;
  logic [2:0] al;
  logic [2:0] cl;
  logic [2:0] wr;
  logic bl8;
  logic seen_clr = 1'b0;
  logic [3:0] bank_open, ap_pending, precharging, ap_start, seen;
  logic [3:0] rd_lat, wr_lat;
  logic [31:0] seed = 32'h94E2D1B0;
  int mismatches = 0;
  int num_checks = 0;
  int n, i, b;

  always #20 clk = ~clk;
  // link clock unrelated in phase to the system clock
  initial
  begin
    #7;
    forever #160 ck = ~ck;
  end

  ctrl_model ctrl (.clk(clk), .ck(ck), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10));

  ddr2_auto_precharge_timing uut (.CLK(clk), .RST(rst), .CK(ck),
    .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba),
    .A10(a10), .AL(al), .CL(cl), .WR(wr), .BL8(bl8),
    .BANK_OPEN(bank_open), .AP_PENDING(ap_pending),
    .PRECHARGING(precharging), .AP_START(ap_start),
    .RD_LATENCY(rd_lat), .WR_LATENCY(wr_lat));

  always @(posedge clk)
    seen <= (rst || seen_clr) ? 4'h0 : (seen | ap_start);

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic int exp_rd(input int a, input logic b8);
    return a + (b8 ? BL8_HALF : BL4_HALF);
  endfunction : exp_rd

  function automatic int exp_wr(input int a, input int c, input int w,
                                input logic b8);
    return a + c - WL_OFS + (b8 ? BL8_HALF : BL4_HALF) + w;
  endfunction : exp_wr

  // only while every bank is idle: the config is static to the design
  task automatic set_cfg();
    seed = lfsr_next(seed);
    @(posedge clk);
    al <= 3'(seed[2:0] % 5);
    cl <= 3'(3 + seed[4:3]);
    wr <= 3'(2 + seed[7:5] % 5);
    bl8 <= seed[8];
    repeat (3) @(posedge clk);
    `CHK("rd_latency", 4'(al) + 4'(cl), rd_lat)
    `CHK("wr_latency", 4'(al) + 4'(cl) - 4'h1, wr_lat)
  endtask : set_cfg

  // link rises from after the command until the start pulse
  task automatic count_start(input int bk, output int cnt);
    int k;
    logic p;
    cnt = 0;
    p = ck;
    for (k = 0; k < 400; k++)
    begin
      @(posedge clk);
      if (ck && !p)
        cnt++;
      p = ck;
      if (ap_start[bk] === 1'b1)
        break;
    end
    if (k == 400)
      cnt = -1;
  endtask : count_start

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  initial
  begin
    #1000000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    al <= 3'h0;
    cl <= 3'h3;
    wr <= 3'h2;
    bl8 <= 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (i = 0; i < 6; i++)
    begin
      set_cfg();
      seed = lfsr_next(seed);
      b = int'(seed[1:0]);
      ctrl.issue(CMD_ACT, 2'(b), 1'b0);
      ctrl.issue(CMD_READ, 2'(b), 1'b0);
      ctrl.gap(3);
      `CHK("open_plain", 1'b1, bank_open[b])
      `CHK("pend_plain", 1'b0, ap_pending[b])
      ctrl.issue(CMD_READ, 2'(b), 1'b1);
      repeat (2) @(posedge clk);
      `CHK("pend_ap", 1'b1, ap_pending[b])
      count_start(b, n);
      `CHK("rd_ap_rises", exp_rd(al, bl8), n)
      @(posedge clk);
      `CHK("prech_rd", 1'b1, precharging[b])
      ctrl.gap(4);
      `CHK("closed_rd", 1'b0, bank_open[b])
      ctrl.issue(CMD_ACT, 2'(b), 1'b0);
      ctrl.issue(CMD_WRITE, 2'(b), 1'b1);
      count_start(b, n);
      `CHK("wr_ap_rises", exp_wr(al, cl, wr, bl8), n)
      ctrl.gap(4);
      `CHK("closed_wr", 1'b0, bank_open[b])
    end
    // all four banks auto-precharging, one read AP after another
    set_cfg();
    @(posedge clk);
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
    for (i = 0; i < 4; i++)
      ctrl.issue(CMD_ACT, 2'(i), 1'b0);
    for (i = 0; i < 4; i++)
      ctrl.issue(CMD_READ, 2'(i), 1'b1);
    ctrl.gap(14);
    `CHK("all_started", 4'hF, seen)
    `CHK("all_closed", 4'h0, bank_open)
    // explicit single-bank and all-bank precharge
    ctrl.issue(CMD_ACT, 2'h2, 1'b0);
    ctrl.issue(CMD_ACT, 2'h1, 1'b0);
    ctrl.issue(CMD_PRE, 2'h2, 1'b0);
    ctrl.gap(3);
    `CHK("pre_one", 4'h2, bank_open)
    ctrl.issue(CMD_ACT, 2'h0, 1'b0);
    ctrl.issue(CMD_PRE, 2'h3, 1'b1);
    ctrl.gap(3);
    `CHK("pre_all", 4'h0, bank_open)
    `CHK("idle_pend", 4'h0, ap_pending)
    report_and_stop();
  end
endmodule : ddr2_auto_precharge_timing_tb_top
